// ### rtl/dceu_pkg.sv
// Package: constants and carrier types for the modem serial port
package dceu_pkg;

  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned WAKE_MS        = 15;
  localparam int unsigned WAKE_CYC       = CLK_HZ / 1000 * WAKE_MS;
  localparam int unsigned RING_MS        = 1000;
  localparam int unsigned RING_CYC       = CLK_HZ / 1000 * RING_MS;

  // ==========================================================
  // Baud rate table
  localparam int unsigned NUM_RATES      = 11;
  localparam logic [3:0]  RATE_MAX       = 4'hA;
  localparam logic [3:0]  RATE_RESET     = 4'h9;

  function automatic logic [19:0] dceu_bit_cycles(input logic [3:0] r);
    int unsigned bps;
    bps = 300;
    case (r)
      4'h0: bps = 300;
      4'h1: bps = 600;
      4'h2: bps = 1200;
      4'h3: bps = 2400;
      4'h4: bps = 4800;
      4'h5: bps = 9600;
      4'h6: bps = 19200;
      4'h7: bps = 38400;
      4'h8: bps = 57600;
      4'h9: bps = 115200;
      default: bps = 230400;
    endcase
    return 20'(CLK_HZ / bps);
  endfunction : dceu_bit_cycles

  // ==========================================================
  // Flow control, parity and in-band characters
  typedef enum logic [1:0] {
    DCEU_FLOW_NONE, DCEU_FLOW_HW, DCEU_FLOW_SW
  } dceu_flow_t;

  typedef enum logic [1:0] {
    DCEU_PAR_NONE, DCEU_PAR_ODD, DCEU_PAR_EVEN
  } dceu_par_t;

  localparam logic [7:0]  CHAR_XON       = 8'h11;
  localparam logic [7:0]  CHAR_XOFF      = 8'h13;

  typedef struct packed {
    logic [3:0] rate;
    logic       autobaud;
    dceu_flow_t flow;
    dceu_par_t  parity;
    logic       two_stop;
  } dceu_cfg_t;

  localparam dceu_cfg_t CFG_RESET = '{rate: RATE_RESET, autobaud: 1'b1,
    flow: DCEU_FLOW_HW, parity: DCEU_PAR_NONE, two_stop: 1'b0};

  typedef struct packed {
    logic       parity_err;
    logic       frame_err;
    logic [3:0] rate;
    logic       rate_locked;
  } dceu_status_t;

endpackage : dceu_pkg

// ### rtl/dceu_fifo.sv
// FIFO between the host-side user and the serial transmitter
`timescale 1ns/1ps
module dceu_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             resetn,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // Drain side
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  always_comb begin
    push  = in_valid && (cnt_q != (AW+1)'(DEPTH));
    pop   = out_ready && (cnt_q != '0);
    wr_d  = push ? wr_q + 1'b1 : wr_q;
    rd_d  = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_q];

endmodule : dceu_fifo

// ### rtl/dceu_port.sv
// Modem-side serial port: framing, flow control, autobaud, ring, sleep
`timescale 1ns/1ps
// Notes on behaviour
// - Eleven baud rates from 300 to 230400 bit/s are selectable.
// - Rate is learnt from the host's first start bit when autobaud is on.
// - Flow control: hardware lines gate sending in every mode, plus in-band XON/XOFF when selected.
// - Parity and number of stop bits are configurable.
// - Reset: 8N1, hardware flow control, autobaud active.
// - No new character starts while terminal-ready or request-to-send is high.
// - Every serial pin is active low.
// - Incoming call pulses the ring indicator, never a steady level.
// - Device is DCE: it drives receive data, host drives transmit data.
// - Eight signals: two data lines, six control and status lines.
// - In sleep reception and new transmission stop and clear-to-send stays high.
// - After wake clear-to-send stays high 15 ms; no host data taken.
module dceu_port #(
  parameter int unsigned FIFO_DEPTH = 16,
  parameter int unsigned WAKE_CYCLES = dceu_pkg::WAKE_CYC,
  parameter int unsigned RING_CYCLES = dceu_pkg::RING_CYC
) (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 resetn,
  // Serial pins, DCE view, all active low
  input  wire logic                 txd_n,
  output logic                      rxd_n,
  input  wire logic                 dtr_n,
  input  wire logic                 rts_n,
  output logic                      cts_n,
  output logic                      dsr_n,
  output logic                      dcd_n,
  output logic                      ri_n,
  // Configuration and control
  input  wire dceu_pkg::dceu_cfg_t  cfg,
  input  wire logic                 sleep,
  input  wire logic                 carrier,
  input  wire logic                 ring_call,
  // Data toward the host
  input  wire logic [7:0]           tx_data,
  input  wire logic                 tx_valid,
  output logic                      tx_ready,
  // Data from the host
  output logic [7:0]                rx_data,
  output logic                      rx_valid,
  output dceu_pkg::dceu_status_t    status
);
  typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} dceu_st_t;

  function automatic logic par_bit(input logic [7:0] d,
                                   input dceu_pkg::dceu_par_t p);
    return (^d) ^ (p == dceu_pkg::DCEU_PAR_ODD);
  endfunction : par_bit

  function automatic logic [19:0] dceu_bit_rate_mid(input logic [3:0] r);
    return (dceu_pkg::dceu_bit_cycles(r) >> 1) +
           (dceu_pkg::dceu_bit_cycles(r) >> 2);
  endfunction : dceu_bit_rate_mid

  // ==========================================================
  // Pin synchronisers
  logic [1:0] txd_s, dtr_s, rts_s;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      txd_s <= 2'h3;
      dtr_s <= 2'h3;
      rts_s <= 2'h3;
    end else begin
      txd_s <= {txd_s[0], txd_n};
      dtr_s <= {dtr_s[0], dtr_n};
      rts_s <= {rts_s[0], rts_n};
    end
  end
  logic rxl, dtr_hi, rts_hi;
  assign rxl    = txd_s[1];
  assign dtr_hi = dtr_s[1];
  assign rts_hi = rts_s[1];

  // ==========================================================
  // Wake timer and active flag
  logic [31:0] wake_q, wake_d;
  logic        act;
  always_comb begin
    wake_d = wake_q;
    if (sleep) begin
      wake_d = 32'(WAKE_CYCLES);
    end else if (wake_q != '0) begin
      wake_d = wake_q - 32'h1;
    end
  end
  assign act = !sleep && (wake_q == '0);

  // ==========================================================
  // Rate selection and autobaud
  logic [3:0]  rate_q, rate_d;
  logic        lock_q, lock_d;
  logic [19:0] ab_cnt_q, ab_cnt_d;
  logic        ab_run_q, ab_run_d;
  logic        rxl_q;
  always_comb begin
    rate_d   = rate_q;
    lock_d   = lock_q;
    ab_cnt_d = ab_cnt_q;
    ab_run_d = ab_run_q;
    if (!cfg.autobaud) begin
      rate_d = (cfg.rate > dceu_pkg::RATE_MAX) ? dceu_pkg::RATE_MAX
                                                : cfg.rate;
      lock_d = 1'b1;
    end else if (!lock_q && act) begin
      if (!ab_run_q && rxl_q && !rxl) begin
        ab_run_d = 1'b1;
        ab_cnt_d = '0;
      end else if (ab_run_q && !rxl) begin
        ab_cnt_d = ab_cnt_q + 20'h1;
      end else if (ab_run_q) begin
        ab_run_d = 1'b0;
        lock_d   = 1'b1;
        rate_d   = dceu_pkg::RATE_MAX;
        for (int i = 0; i < int'(dceu_pkg::NUM_RATES); i++) begin
          if (ab_cnt_q > (dceu_bit_rate_mid(4'(i)))) begin
            rate_d = 4'(i);
            break;
          end
        end
      end
    end
  end

  logic [19:0] bitlen;
  assign bitlen = dceu_pkg::dceu_bit_cycles(rate_q);

  // ==========================================================
  // Receiver
  dceu_st_t    rs_q, rs_d;
  logic [19:0] rc_q, rc_d;
  logic [2:0]  rb_q, rb_d;
  logic [7:0]  rsh_q, rsh_d, rxd_q, rxd_d;
  logic        rv_q, rv_d, pe_q, pe_d, fe_q, fe_d;
  logic        xoff_q, xoff_d;
  always_comb begin
    rs_d = rs_q; rc_d = rc_q; rb_d = rb_q; rsh_d = rsh_q; rxd_d = rxd_q;
    rv_d = 1'b0; pe_d = pe_q; fe_d = fe_q;
    xoff_d = xoff_q;
    if (cfg.flow != dceu_pkg::DCEU_FLOW_SW) xoff_d = 1'b0;
    case (rs_q)
      S_IDLE: begin
        if (act && lock_q && !rxl) begin
          rs_d = S_START;
          rc_d = bitlen >> 1;
        end
      end
      S_START: begin
        if (rc_q != '0) rc_d = rc_q - 20'h1;
        else if (rxl) rs_d = S_IDLE;
        else begin
          rs_d = S_DATA; rc_d = bitlen - 20'h1; rb_d = '0;
        end
      end
      S_DATA: begin
        if (rc_q != '0) rc_d = rc_q - 20'h1;
        else begin
          rsh_d = {rxl, rsh_q[7:1]};
          rc_d  = bitlen - 20'h1;
          rb_d  = rb_q + 3'h1;
          if (rb_q == 3'h7) begin
            rs_d = (cfg.parity != dceu_pkg::DCEU_PAR_NONE) ? S_PAR : S_STOP;
          end
        end
      end
      S_PAR: begin
        if (rc_q != '0) rc_d = rc_q - 20'h1;
        else begin
          pe_d = (rxl != par_bit(rsh_q, cfg.parity));
          rc_d = bitlen - 20'h1;
          rs_d = S_STOP;
        end
      end
      default: begin
        if (rc_q != '0) rc_d = rc_q - 20'h1;
        else begin
          fe_d = !rxl;
          rs_d = S_IDLE;
          if (rxl && cfg.flow == dceu_pkg::DCEU_FLOW_SW &&
              rsh_q == dceu_pkg::CHAR_XOFF) xoff_d = 1'b1;
          else if (rxl && cfg.flow == dceu_pkg::DCEU_FLOW_SW &&
                   rsh_q == dceu_pkg::CHAR_XON) xoff_d = 1'b0;
          else if (rxl) begin
            rxd_d = rsh_q; rv_d = 1'b1;
          end
        end
      end
    endcase
    if (!act) begin
      rs_d = S_IDLE;
      rv_d = 1'b0;
    end
  end

  // ==========================================================
  // Transmitter fed through the FIFO
  logic [7:0]  fdat;
  logic        fval, fpop;
  dceu_st_t    ts_q, ts_d;
  logic [19:0] tc_q, tc_d;
  logic [2:0]  tb_q, tb_d;
  logic [7:0]  tsh_q, tsh_d;
  logic        tl_q, tl_d, ts2_q, ts2_d, gate;

  dceu_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .resetn    (resetn),
    .in_data   (tx_data),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (fdat),
    .out_valid (fval),
    .out_ready (fpop)
  );

  always_comb begin
    gate = act && !dtr_hi && !rts_hi && !xoff_q;
    fpop = (ts_q == S_IDLE) && fval && gate;
    ts_d = ts_q; tc_d = tc_q; tb_d = tb_q; tsh_d = tsh_q;
    tl_d = tl_q; ts2_d = ts2_q;
    if (ts_q != S_IDLE && tc_q != '0) tc_d = tc_q - 20'h1;
    else begin
      case (ts_q)
        S_IDLE: begin
          tl_d = 1'b1;
          if (fpop) begin
            tsh_d = fdat; tl_d = 1'b0;
            tc_d = bitlen - 20'h1; ts_d = S_DATA; tb_d = '0;
          end
        end
        S_DATA: begin
          tl_d = tsh_q[tb_q]; tc_d = bitlen - 20'h1;
          tb_d = tb_q + 3'h1;
          if (tb_q == 3'h7) begin
            ts_d = (cfg.parity != dceu_pkg::DCEU_PAR_NONE) ? S_PAR : S_STOP;
            ts2_d = cfg.two_stop;
          end
        end
        S_PAR: begin
          tl_d = par_bit(tsh_q, cfg.parity);
          tc_d = bitlen - 20'h1; ts_d = S_STOP;
        end
        default: begin
          tl_d = 1'b1; tc_d = bitlen - 20'h1;
          if (ts2_q) ts2_d = 1'b0;
          else ts_d = S_START;
        end
      endcase
      if (ts_q == S_START) ts_d = S_IDLE;
    end
  end

  // ==========================================================
  // Ring pulse and control outputs
  logic [31:0] ring_q, ring_d;
  logic        ri_q, ri_d, cts_q, cts_d, dsr_q, dcd_q;
  logic [31:0] ri_low_q, ri_low_d;
  always_comb begin
    ring_d = ring_q;
    ri_d   = ri_q;
    if (ring_q != '0) ring_d = ring_q - 32'h1;
    else if (!ri_q) ri_d = 1'b1;
    else if (ring_call) begin
      ri_d = 1'b0; ring_d = 32'(RING_CYCLES) - 32'h1;
    end
    cts_d = !act;
    // Length of the ring pulse so far
    ri_low_d = ri_q ? 32'h0 : ri_low_q + 32'h1;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wake_q <= '0; rate_q <= dceu_pkg::RATE_RESET; lock_q <= 1'b0;
      ab_cnt_q <= '0; ab_run_q <= 1'b0; rxl_q <= 1'b1;
      rs_q <= S_IDLE; rc_q <= '0; rb_q <= '0; rsh_q <= '0; rxd_q <= '0;
      rv_q <= 1'b0; pe_q <= 1'b0; fe_q <= 1'b0;
      xoff_q <= 1'b0; ts_q <= S_IDLE; tc_q <= '0; tb_q <= '0;
      tsh_q <= '0; tl_q <= 1'b1; ts2_q <= 1'b0; ring_q <= '0;
      ri_q <= 1'b1; cts_q <= 1'b1; dsr_q <= 1'b1; dcd_q <= 1'b1;
      ri_low_q <= '0;
    end else begin
      wake_q <= wake_d; rate_q <= rate_d; lock_q <= lock_d;
      ab_cnt_q <= ab_cnt_d; ab_run_q <= ab_run_d; rxl_q <= rxl;
      rs_q <= rs_d; rc_q <= rc_d; rb_q <= rb_d; rsh_q <= rsh_d;
      rxd_q <= rxd_d; rv_q <= rv_d; pe_q <= pe_d; fe_q <= fe_d;
      xoff_q <= xoff_d; ts_q <= ts_d; tc_q <= tc_d;
      tb_q <= tb_d; tsh_q <= tsh_d; tl_q <= tl_d; ts2_q <= ts2_d;
      ring_q <= ring_d; ri_q <= ri_d; cts_q <= cts_d;
      ri_low_q <= ri_low_d;
      dsr_q <= !act;
      dcd_q <= !carrier;
    end
  end

  // Outputs, DCE drives receive data toward the host
  assign rxd_n    = tl_q;
  assign cts_n    = cts_q;
  assign dsr_n    = dsr_q;
  assign dcd_n    = dcd_q;
  assign ri_n     = ri_q;
  assign rx_data  = rxd_q;
  assign rx_valid = rv_q;
  assign status   = '{parity_err: pe_q, frame_err: fe_q, rate: rate_q,
                      rate_locked: lock_q};

  // ==========================================================
  // Assertions
  property p_gate_tx;
    @(posedge clock) disable iff (!resetn)
      (ts_q == S_IDLE && (dtr_hi || rts_hi)) |=> (ts_q == S_IDLE);
  endproperty
  a_gate_tx: assert property (p_gate_tx) else $error("tx started gated");

  property p_sleep_cts;
    @(posedge clock) disable iff (!resetn) sleep |=> cts_n;
  endproperty
  a_sleep_cts: assert property (p_sleep_cts) else $error("cts low asleep");

  property p_wake_cts;
    @(posedge clock) disable iff (!resetn)
      $fell(sleep) |=> cts_n [*8];
  endproperty
  a_wake_cts: assert property (p_wake_cts) else $error("cts early");

  property p_ri_pulse;
    @(posedge clock) disable iff (!resetn)
      !ri_n |-> (ri_low_q < 32'(RING_CYCLES));
  endproperty
  a_ri_pulse: assert property (p_ri_pulse) else $error("ri stuck");

  property p_idle_high;
    @(posedge clock) disable iff (!resetn) (ts_q == S_IDLE) |-> rxd_n;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line not idle");

  property p_start_low;
    @(posedge clock) disable iff (!resetn) fpop |=> !rxd_n;
  endproperty
  a_start_low: assert property (p_start_low) else $error("no start bit");

  property p_rate_legal;
    @(posedge clock) disable iff (!resetn) rate_q <= dceu_pkg::RATE_MAX;
  endproperty
  a_rate_legal: assert property (p_rate_legal) else $error("bad rate");

  property p_no_rx_inactive;
    @(posedge clock) disable iff (!resetn) !act |=> !rx_valid;
  endproperty
  a_no_rx_inactive: assert property (p_no_rx_inactive)
    else $error("rx while inactive");

  c_tx: cover property (@(posedge clock) disable iff (!resetn) fpop);
  c_rx: cover property (@(posedge clock) disable iff (!resetn) rx_valid);
  c_ring: cover property (@(posedge clock) disable iff (!resetn) !ri_n);

endmodule : dceu_port

// ### test/dceu_host_model.sv
// Host terminal model for the modem serial port
`timescale 1ns/1ps
// ==========
// Host model
module dceu_host_model #(
  parameter int BITC = 434
) (
  // Clock
  input  wire logic                clock,
  // Serial lines, host view
  output logic                     txd_n,
  input  wire logic                rxd_n,
  // Frame format
  input  wire dceu_pkg::dceu_par_t par,
  input  wire logic                two_stop
);
  logic [7:0] got_q[$];
  logic [7:0] r;
  int         n_err = 0;

  initial txd_n = 1'b1;

  // Host drives transmit data toward the device
  task automatic send(input logic [7:0] d, input logic bad);
    logic [10:0] f;
    logic        p;
    int          nb;
    p  = ~^d ^ (par == dceu_pkg::DCEU_PAR_EVEN) ^ bad;
    if (par == dceu_pkg::DCEU_PAR_NONE) p = 1'b1;
    f  = {2'b11, p, d};
    nb = 9 + int'(par != dceu_pkg::DCEU_PAR_NONE) + int'(two_stop);
    @(posedge clock);
    txd_n <= 1'b0;
    repeat (BITC) @(posedge clock);
    for (int i = 0; i < nb; i++) begin
      txd_n <= f[i];
      repeat (BITC) @(posedge clock);
    end
  endtask : send

  // Receiver of the device's data, sampled mid bit
  always begin
    @(negedge rxd_n);
    repeat (BITC / 2) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      repeat (BITC) @(posedge clock);
      r[i] = rxd_n;
    end
    if (par != dceu_pkg::DCEU_PAR_NONE) begin
      repeat (BITC) @(posedge clock);
      if (rxd_n !== (~^r ^ (par == dceu_pkg::DCEU_PAR_EVEN))) n_err++;
    end
    repeat (BITC) @(posedge clock);
    if (rxd_n !== 1'b1) n_err++;
    got_q.push_back(r);
  end
endmodule : dceu_host_model

// ### test/dceu_port_test.sv
// Self-checking bench for the modem serial port
`timescale 1ns/1ps
// ==========
// Bench top
module dceu_port_test;
  localparam int BITC = 434;
  logic clock, resetn, txd_n, rxd_n, dtr_n, rts_n, cts_n, dsr_n, dcd_n;
  logic ri_n, sleep, carrier, ring_call, tx_valid, tx_ready, rx_valid;
  logic [7:0]             tx_data, rx_data, b;
  logic [7:0]             exp_q[$];
  dceu_pkg::dceu_cfg_t    cfg;
  dceu_pkg::dceu_status_t status;
  int n_mismatch, samples_checked, seed, cyc, n;

  dceu_port #(.FIFO_DEPTH(4), .WAKE_CYCLES(20), .RING_CYCLES(50)) i_dut (
    .clock(clock), .resetn(resetn), .txd_n(txd_n), .rxd_n(rxd_n),
    .dtr_n(dtr_n), .rts_n(rts_n), .cts_n(cts_n), .dsr_n(dsr_n),
    .dcd_n(dcd_n), .ri_n(ri_n), .cfg(cfg), .sleep(sleep),
    .carrier(carrier), .ring_call(ring_call), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .status(status));
  dceu_host_model #(.BITC(BITC)) i_host (.clock(clock), .txd_n(txd_n),
    .rxd_n(rxd_n), .par(cfg.parity), .two_stop(cfg.two_stop));

  // ==========
  // Checking and reporting
  task automatic chk8(input string nm, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8
  task automatic chk1(input string nm, input logic e, g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask : chk1
  task automatic final_report;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  // ==========
  // Stimulus helpers
  task automatic rx_byte(input logic [7:0] d, input logic bad);
    logic seen;
    seen = 1'b0;
    fork
      i_host.send(d, bad);
      begin
        n = 0;
        while (!seen && n < 14 * BITC) begin
          @(posedge clock);
          n++;
          if (rx_valid === 1'b1) seen = 1'b1;
        end
      end
    join
    repeat (4) @(posedge clock);
    if (!bad) chk1("rx_valid", 1'b1, seen);
    if (!bad) chk8("rx_data", d, rx_data);
    chk1("parity_err", bad, status.parity_err);
    chk1("frame_err", 1'b0, status.frame_err);
  endtask : rx_byte
  task automatic fill(input int max);
    n = 0;
    @(posedge clock);
    tx_data  <= 8'($random(seed));
    tx_valid <= 1'b1;
    while (n < max) begin
      @(negedge clock);
      if (tx_ready !== 1'b1) begin
        @(posedge clock);
        break;
      end
      @(posedge clock);
      exp_q.push_back(tx_data);
      tx_data <= 8'($random(seed));
      n++;
    end
    tx_valid <= 1'b0;
  endtask : fill
  task automatic hold_idle(input int cyc_n);
    int lows;
    lows = 0;
    repeat (cyc_n) begin
      @(posedge clock);
      if (rxd_n !== 1'b1) lows++;
    end
    chk1("rxd_n idle", 1'b1, lows == 0);
  endtask : hold_idle
  task automatic cmp_tx(input int k);
    n = 0;
    while (i_host.got_q.size() < k && n < 60 * BITC) begin
      @(posedge clock);
      n++;
    end
    chk8("host count", 8'(k), 8'(i_host.got_q.size()));
    while (exp_q.size() > 0 && i_host.got_q.size() > 0)
      chk8("host byte", exp_q.pop_front(), i_host.got_q.pop_front());
    chk8("host frame errors", 8'h00, 8'(i_host.n_err));
    exp_q.delete();
  endtask : cmp_tx

  // ==========
  // Clock and time limit
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 100000) begin
      n_mismatch++;
      final_report();
    end
  end

  // ==========
  // Main sequence
  initial begin
    seed = 88;
    cyc = 0;
    n_mismatch = 0;
    samples_checked = 0;
    resetn = 1'b0;
    dtr_n = 1'b0;
    rts_n = 1'b0;
    sleep = 1'b0;
    carrier = 1'b0;
    ring_call = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    cfg = dceu_pkg::CFG_RESET;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    chk1("rxd_n", 1'b1, rxd_n);
    chk1("ri_n", 1'b1, ri_n);
    chk8("rate", 8'h09, 8'(status.rate));
    chk1("rate_locked", 1'b0, status.rate_locked);
    repeat (60) @(posedge clock);
    chk1("cts_n", 1'b0, cts_n);
    chk1("dsr_n", 1'b0, dsr_n);
    $display("test reset done");
    i_host.send(8'h55, 1'b0);
    // Let the tail of the measuring character drain from the receiver
    repeat (2 * BITC) @(posedge clock);
    chk8("rate", 8'h0A, 8'(status.rate));
    chk1("rate_locked", 1'b1, status.rate_locked);
    $display("test autobaud done");
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      cfg.parity <= dceu_pkg::dceu_par_t'(i);
      cfg.two_stop <= (i == 1);
      @(posedge clock);
      b = 8'($random(seed));
      rx_byte(b, 1'b0);
    end
    rx_byte(8'($random(seed)), 1'b1);
    $display("test receive done");
    @(posedge clock);
    cfg.flow <= dceu_pkg::DCEU_FLOW_NONE;
    dtr_n <= 1'b1;
    fill(8);
    chk8("accepted", 8'h04, 8'(n));
    hold_idle(3 * BITC);
    cfg.flow <= dceu_pkg::DCEU_FLOW_HW;
    dtr_n <= 1'b0;
    n = 0;
    while (rxd_n === 1'b1 && n < 200) begin
      @(posedge clock);
      n++;
    end
    rts_n <= 1'b1;
    repeat (12 * BITC) @(posedge clock);
    hold_idle(4 * BITC);
    chk8("host count", 8'h01, 8'(i_host.got_q.size()));
    rts_n <= 1'b0;
    cmp_tx(4);
    $display("test transmit done");
    @(posedge clock);
    cfg.flow <= dceu_pkg::DCEU_FLOW_SW;
    i_host.send(dceu_pkg::CHAR_XOFF, 1'b0);
    repeat (100) @(posedge clock);
    fill(1);
    hold_idle(4 * BITC);
    i_host.send(dceu_pkg::CHAR_XON, 1'b0);
    cmp_tx(1);
    $display("test flow done");
    ring_call <= 1'b1;
    @(posedge clock);
    ring_call <= 1'b0;
    repeat (5) @(posedge clock);
    chk1("ri_n", 1'b0, ri_n);
    repeat (60) @(posedge clock);
    chk1("ri_n", 1'b1, ri_n);
    carrier <= 1'b1;
    sleep <= 1'b1;
    repeat (5) @(posedge clock);
    chk1("dcd_n", 1'b0, dcd_n);
    chk1("cts_n", 1'b1, cts_n);
    sleep <= 1'b0;
    repeat (10) @(posedge clock);
    chk1("cts_n", 1'b1, cts_n);
    repeat (30) @(posedge clock);
    chk1("cts_n", 1'b0, cts_n);
    $display("test ring and sleep done");
    final_report();
  end
endmodule : dceu_port_test
